// File: logic/lptp_device.sv
// What this block does
// - Terminate only on even cycles after command.
// - Write terminate stops beats after WL.
// - Read terminate ends output after RL.
// - Per-byte mask blocks that byte's write.
// - Mask sampled exactly like its data beat.
// - Precharge decode: CA0 high, CA1 high, CA2 low, CA3 high.
// - All-bank flag or bank bits pick banks.
// - All-bank precharge delay may exceed per-bank.
// - Array write only after four beats latched.
// - Open bank needs precharge before new row.
// - No auto precharge leaves bank open.
// - Auto precharge bit engages bank close.
// - Read auto precharge at later of two.
// - Terminate decode: CA0 high, CA1 high, CA2 low, CA3 low.
// - Write auto precharge after recovery time.
`timescale 1ns/1ps
`default_nettype none
`include "lptp_params.svh"
module lptp_device
  import lptp_pkg::*;
#(
  parameter int COL_GRP_W = 4
)(
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  input  wire lptp_cfg_s                  cfg_i,
  output logic       [`LPTP_BANKS-1:0]    bank_open_o,
  output logic       [`LPTP_BANKS-1:0]    bank_busy_o,
  input  wire logic                       link_clk_i,
  input  wire logic                       cs_n_i,
  input  wire logic  [`LPTP_CA_W-1:0]     ca_r_i,
  input  wire logic  [`LPTP_CA_W-1:0]     ca_f_i,
  input  wire lptp_pair_s                 wr_pair_i,
  output logic       [2*`LPTP_DQ_W-1:0]   rd_dq_o,
  output logic                            rd_valid_o,
  output logic                            cmd_err_o
);
  localparam int PW    = `LPTP_PH_W;
  localparam int RW    = `LPTP_RP_W;
  localparam int BW    = `LPTP_BA_W;
  localparam int NB    = `LPTP_BANKS;
  localparam int AW    = BW + COL_GRP_W;
  localparam int GBYTE = `LPTP_BEATS_GRP * `LPTP_DM_W;

  // Link reset: asserted at once, released on the link clock.
  logic [1:0] lrst_ff;
  always_ff @(posedge link_clk_i or posedge rst_i)
  begin
    if (rst_i)
      lrst_ff <= 2'b11;
    else
      lrst_ff <= {lrst_ff[0], 1'b0};
  end
  wire logic lrst = lrst_ff[1];

  // Configuration is quasi-static; a value is only taken once two
  // synchronised samples agree, so a word caught mid-change is dropped.
  lptp_cfg_s cfg_s1_ff;
  lptp_cfg_s cfg_s2_ff;
  lptp_cfg_s cfg_s3_ff;
  lptp_cfg_s cfg_ff;
  always_ff @(posedge link_clk_i or posedge lrst)
  begin
    if (lrst)
    begin
      cfg_s1_ff <= '0;
      cfg_s2_ff <= '0;
      cfg_s3_ff <= '0;
      cfg_ff    <= '0;
    end
    else
    begin
      cfg_s1_ff <= cfg_i;
      cfg_s2_ff <= cfg_s1_ff;
      cfg_s3_ff <= cfg_s2_ff;
      if (cfg_s2_ff == cfg_s3_ff)
        cfg_ff <= cfg_s3_ff;
    end
  end

  wire logic [PW-1:0] rl_w   = PW'(cfg_ff.rl);
  wire logic [PW-1:0] wl_w   = PW'(cfg_ff.wl);
  wire logic [PW-1:0] hbl_w  = PW'(cfg_ff.bl >> 1);
  wire logic [PW-1:0] trtp_w = PW'(cfg_ff.trtp_ck);
  wire logic [PW-1:0] twr_w  = PW'(cfg_ff.twr_ck);

  // Command decode on the rising link edge.
  wire logic [`LPTP_OP_W-1:0] opc = ca_r_i[`LPTP_OP_W-1:0];
  wire logic sel     = !cs_n_i;
  wire logic is_act  = sel && ((opc & `LPTP_MSK_ACT) == `LPTP_OPC_ACT);
  wire logic is_rd   = sel && ((opc & `LPTP_MSK_RW) == `LPTP_OPC_READ);
  wire logic is_wr   = sel && ((opc & `LPTP_MSK_RW) == `LPTP_OPC_WRITE);
  wire logic is_pre  = sel && ((opc & `LPTP_MSK_PB) == `LPTP_OPC_PRE);
  wire logic is_bst  = sel && ((opc & `LPTP_MSK_PB) == `LPTP_OPC_BST);
  wire logic all_bk  = ca_r_i[`LPTP_AB_BIT];
  wire logic ap_bit  = ca_f_i[`LPTP_AP_BIT];
  wire logic [BW-1:0] ba_msk = cfg_ff.eight_bank ? `LPTP_BA_MSK8
                                                 : `LPTP_BA_MSK4;
  wire logic [BW-1:0] bank   = ca_r_i[`LPTP_BA_LO +: BW] & ba_msk;
  wire logic [COL_GRP_W-1:0] colg = ca_f_i[`LPTP_COLG_LO +: COL_GRP_W];

  // Per-bank open state and precharge timers.
  logic [NB-1:0] open_ff;
  logic [RW-1:0] rp_ff [NB];
  logic [NB-1:0] rp_busy;
  logic          ap_pend_ff;
  logic [BW-1:0] ap_bank_ff;
  logic [PW-1:0] ap_cnt_ff;
  wire logic     ap_fire = ap_pend_ff && (ap_cnt_ff == `LPTP_PH_ONE);

  wire logic act_ok = is_act && !open_ff[bank] && !rp_busy[bank];
  wire logic ap_blk = ap_pend_ff && (ap_bank_ff == bank);
  wire logic rw_ok  = (is_rd || is_wr) && open_ff[bank] && !ap_blk;

  // Eight-bank parts use the longer all-bank time; four-bank parts
  // use the per-bank time for both.
  wire logic [RW-1:0] rp_all = cfg_ff.eight_bank ? cfg_ff.rp_ab_ck
                                                 : cfg_ff.rp_pb_ck;

  genvar gk;
  generate
    for (gk = 0; gk < NB; gk = gk + 1)
    begin : g_bank
      wire logic pre_hit = is_pre && (all_bk || (bank == BW'(gk)));
      wire logic ap_hit  = ap_fire && (ap_bank_ff == BW'(gk));
      wire logic act_hit = act_ok && (bank == BW'(gk));
      assign rp_busy[gk] = (rp_ff[gk] != '0);
      always_ff @(posedge link_clk_i or posedge lrst)
      begin
        if (lrst)
        begin
          open_ff[gk] <= 1'b0;
          rp_ff[gk]   <= '0;
        end
        else if (pre_hit || ap_hit)
        begin
          open_ff[gk] <= 1'b0;
          rp_ff[gk]   <= (pre_hit && all_bk) ? rp_all
                                             : cfg_ff.rp_pb_ck;
        end
        else
        begin
          if (act_hit)
            open_ff[gk] <= 1'b1;
          if (rp_busy[gk])
            rp_ff[gk] <= rp_ff[gk] - `LPTP_RP_ONE;
        end
      end
    end
  endgenerate

  // Auto precharge start, counted in link cycles from the command.
  wire logic [PW-1:0] rtp_pt = hbl_w - `LPTP_PH_TWO + trtp_w;
  wire logic [PW-1:0] ap_rd  = (rtp_pt > hbl_w) ? rtp_pt : hbl_w;
  wire logic [PW-1:0] ap_wr  = wl_w + hbl_w + `LPTP_PH_ONE + twr_w;

  always_ff @(posedge link_clk_i or posedge lrst)
  begin
    if (lrst)
    begin
      ap_pend_ff <= 1'b0;
      ap_bank_ff <= '0;
      ap_cnt_ff  <= '0;
    end
    else if (rw_ok && ap_bit)
    begin
      ap_pend_ff <= 1'b1;
      ap_bank_ff <= bank;
      ap_cnt_ff  <= is_rd ? ap_rd : ap_wr;
    end
    else if (ap_pend_ff)
    begin
      ap_pend_ff <= !ap_fire;
      ap_cnt_ff  <= ap_cnt_ff - `LPTP_PH_ONE;
    end
  end

  // Burst tracker. phase_ff holds the cycles elapsed since the command.
  lptp_burst_e   state_ff;
  lptp_burst_e   nxt_state;
  logic [PW-1:0] phase_ff;
  logic [PW-1:0] half_ff;
  logic          bst_done_ff;
  logic          ap_bur_ff;
  logic [BW-1:0] bbank_ff;

  wire logic active = (state_ff != BURST_IDLE);
  // Even cycle, inside the programmed burst, once only, not on an
  // auto precharge burst.
  wire logic bst_ok = is_bst && active && !bst_done_ff && !ap_bur_ff
                      && !phase_ff[0] && (phase_ff < hbl_w);
  wire logic [PW-1:0] lat   = (state_ff == BURST_READ) ? rl_w : wl_w;
  wire logic          b_end = active && (phase_ff == lat + half_ff);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      BURST_IDLE:
        if (rw_ok)
          nxt_state = is_rd ? BURST_READ : BURST_WRITE;
      BURST_READ, BURST_WRITE:
        if (rw_ok)
          nxt_state = is_rd ? BURST_READ : BURST_WRITE;
        else if (b_end)
          nxt_state = BURST_IDLE;
      default:
        nxt_state = BURST_IDLE;
    endcase
  end

  always_ff @(posedge link_clk_i or posedge lrst)
  begin
    if (lrst)
    begin
      state_ff    <= BURST_IDLE;
      phase_ff    <= '0;
      half_ff     <= '0;
      bst_done_ff <= 1'b0;
      ap_bur_ff   <= 1'b0;
      bbank_ff    <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (rw_ok)
      begin
        phase_ff    <= `LPTP_PH_ONE;
        half_ff     <= hbl_w;
        bst_done_ff <= 1'b0;
        ap_bur_ff   <= ap_bit;
        bbank_ff    <= bank;
      end
      else
      begin
        if (active)
          phase_ff <= phase_ff + `LPTP_PH_ONE;
        if (bst_ok)
        begin
          half_ff     <= phase_ff;
          bst_done_ff <= 1'b1;
        end
      end
    end
  end

  // Read path: a group is fetched two cycles before its first beat pair.
  wire logic [PW-1:0] rrel   = phase_ff + `LPTP_PH_TWO - rl_w;
  wire logic [PW-1:0] orel   = phase_ff + `LPTP_PH_ONE - rl_w;
  wire logic rd_issue = (state_ff == BURST_READ) && !rw_ok
                        && (phase_ff + `LPTP_PH_TWO >= rl_w)
                        && !rrel[0] && (rrel < half_ff);
  wire logic rd_load  = (state_ff == BURST_READ) && !rw_ok
                        && (phase_ff + `LPTP_PH_ONE >= rl_w)
                        && (orel < half_ff);

  // Write path: beat pairs are taken in the write window.
  wire logic [PW-1:0] wrel   = phase_ff - wl_w;
  wire logic wr_take  = (state_ff == BURST_WRITE) && !rw_ok
                        && (phase_ff >= wl_w) && (wrel < half_ff);
  wire logic wr_last  = wr_take && wrel[0];

  logic [COL_GRP_W-1:0] grp_ff;
  lptp_pair_s           wlo_ff;
  lptp_pair_s           whi_ff;
  logic                 wr_go_ff;
  logic [AW-1:0]        wr_addr_ff;
  logic [8*GBYTE-1:0]   rdata;

  always_ff @(posedge link_clk_i or posedge lrst)
  begin
    if (lrst)
    begin
      grp_ff     <= '0;
      wlo_ff     <= '0;
      whi_ff     <= '0;
      wr_go_ff   <= 1'b0;
      wr_addr_ff <= '0;
    end
    else
    begin
      wr_go_ff <= wr_last;
      if (rw_ok)
        grp_ff <= colg;
      else if (rd_issue || wr_last)
        grp_ff <= grp_ff + 1'b1;
      // Mask bits ride in the same pair as their data beats.
      if (wr_take && !wrel[0])
        wlo_ff <= wr_pair_i;
      if (wr_last)
      begin
        whi_ff     <= wr_pair_i;
        wr_addr_ff <= {bbank_ff, grp_ff};
      end
    end
  end

  // The array is written one cycle after its fourth beat.
  lptp_mem
  #(
    .BYTES (GBYTE),
    .AW    (AW)
  ) u_mem (
    .clk_i   (link_clk_i),
    .rst_i   (lrst),
    .we_i    (wr_go_ff),
    .waddr_i (wr_addr_ff),
    .wdata_i ({whi_ff.dq, wlo_ff.dq}),
    .wbe_i   (~{whi_ff.dm, wlo_ff.dm}),
    .re_i    (rd_issue),
    .raddr_i ({bbank_ff, grp_ff}),
    .rdata_o (rdata)
  );

  logic ncmd_err;
  assign ncmd_err = (is_act && !act_ok)
                    || ((is_rd || is_wr) && !rw_ok)
                    || (is_bst && !bst_ok);

  always_ff @(posedge link_clk_i or posedge lrst)
  begin
    if (lrst)
    begin
      rd_dq_o    <= '0;
      rd_valid_o <= 1'b0;
      cmd_err_o  <= 1'b0;
    end
    else
    begin
      rd_valid_o <= rd_load;
      cmd_err_o  <= ncmd_err;
      if (rd_load)
        rd_dq_o <= orel[0] ? rdata[2*`LPTP_DQ_W +: 2*`LPTP_DQ_W]
                           : rdata[0 +: 2*`LPTP_DQ_W];
    end
  end

  // Bank status back to the core clock, one level per bit.
  logic [NB-1:0] busy_lv;
  logic [NB-1:0] open_s1_ff;
  logic [NB-1:0] busy_s1_ff;
  generate
    for (gk = 0; gk < NB; gk = gk + 1)
    begin : g_busy
      assign busy_lv[gk] = rp_busy[gk]
                           || (ap_pend_ff && (ap_bank_ff == BW'(gk)));
    end
  endgenerate

  logic [NB-1:0] busy_ff;
  always_ff @(posedge link_clk_i or posedge lrst)
  begin
    if (lrst)
      busy_ff <= '0;
    else
      busy_ff <= busy_lv;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      open_s1_ff  <= '0;
      busy_s1_ff  <= '0;
      bank_open_o <= '0;
      bank_busy_o <= '0;
    end
    else
    begin
      open_s1_ff  <= open_ff;
      busy_s1_ff  <= busy_ff;
      bank_open_o <= open_s1_ff;
      bank_busy_o <= busy_s1_ff;
    end
  end
endmodule
`default_nettype wire

// File: shared/lptp_params.svh
`ifndef LPTP_PARAMS_SVH
`define LPTP_PARAMS_SVH

`define LPTP_CA_W       10
`define LPTP_DQ_W       32
`define LPTP_DM_W       4
`define LPTP_BANKS      8
`define LPTP_BA_W       3
`define LPTP_BA_LO      7
`define LPTP_AB_BIT     4
`define LPTP_AP_BIT     0
`define LPTP_COLG_LO    1
`define LPTP_OP_W       4
`define LPTP_OPC_ACT    4'h2
`define LPTP_MSK_ACT    4'h3
`define LPTP_OPC_READ   4'h5
`define LPTP_OPC_WRITE  4'h1
`define LPTP_MSK_RW     4'h7
`define LPTP_OPC_PRE    4'hB
`define LPTP_OPC_BST    4'h3
`define LPTP_MSK_PB     4'hF
`define LPTP_BA_MSK8    3'h7
`define LPTP_BA_MSK4    3'h3
`define LPTP_PH_W       6
`define LPTP_RP_W       6
`define LPTP_LAT_W      4
`define LPTP_BL_W       5
`define LPTP_PH_ONE     6'h01
`define LPTP_PH_TWO     6'h02
`define LPTP_RP_ONE     6'h01
`define LPTP_BEATS_GRP  4

`endif

// File: shared/lptp_pkg.sv
package lptp_pkg;
  `include "lptp_params.svh"

  typedef enum logic [1:0]
  {
    BURST_IDLE  = 2'b00,
    BURST_READ  = 2'b01,
    BURST_WRITE = 2'b10
  } lptp_burst_e;

  typedef struct packed
  {
    logic [`LPTP_BL_W-1:0]  bl;
    logic [`LPTP_LAT_W-1:0] rl;
    logic [`LPTP_LAT_W-1:0] wl;
    logic [`LPTP_LAT_W-1:0] trtp_ck;
    logic [`LPTP_LAT_W-1:0] twr_ck;
    logic [`LPTP_RP_W-1:0]  rp_pb_ck;
    logic [`LPTP_RP_W-1:0]  rp_ab_ck;
    logic                   eight_bank;
  } lptp_cfg_s;

  typedef struct packed
  {
    logic [1:0][`LPTP_DQ_W-1:0] dq;
    logic [1:0][`LPTP_DM_W-1:0] dm;
  } lptp_pair_s;
endpackage

// File: logic/lptp_mem.sv
`timescale 1ns/1ps
`default_nettype none
module lptp_mem
#(
  parameter int BYTES = 16,
  parameter int AW    = 7
)(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               we_i,
  input  wire logic [AW-1:0]      waddr_i,
  input  wire logic [8*BYTES-1:0] wdata_i,
  input  wire logic [BYTES-1:0]   wbe_i,
  input  wire logic               re_i,
  input  wire logic [AW-1:0]      raddr_i,
  output logic      [8*BYTES-1:0] rdata_o
);
  // One array per byte lane, so each lane has exactly one writer.
  logic [7:0]         mem [BYTES][2**AW];
  logic [8*BYTES-1:0] rd_w;

  genvar gb;
  generate
    for (gb = 0; gb < BYTES; gb = gb + 1)
    begin : g_byte
      always_ff @(posedge clk_i)
      begin
        if (we_i && wbe_i[gb])
          mem[gb][waddr_i] <= wdata_i[gb*8 +: 8];
      end
      assign rd_w[gb*8 +: 8] = mem[gb][raddr_i];
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= '0;
    else if (re_i)
      rdata_o <= rd_w;
  end
endmodule
`default_nettype wire

// File: logic/lptp_device_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: verification/lptp_device_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "lptp_params.svh"
module lptp_device_props
  import lptp_pkg::*;
(
  input wire logic            rst_i,
  input wire lptp_cfg_s       cfg_i,
  input wire logic [7:0]      bank_open_o,
  input wire logic [7:0]      bank_busy_o,
  input wire logic            link_clk_i,
  input wire logic            cs_n_i,
  input wire logic [9:0]      ca_r_i,
  input wire logic [9:0]      ca_f_i,
  input wire logic            rd_valid_o,
  input wire logic            cmd_err_o
);
  default clocking @(posedge link_clk_i); endclocking
  default disable iff (rst_i);
  logic [4:0] since_rw_ff;
  logic [4:0] since_rd_ff;
  wire logic [3:0] opc = ca_r_i[3:0];
  wire logic       pre = !cs_n_i && opc == `LPTP_OPC_PRE;
  wire logic       bst = !cs_n_i && opc == `LPTP_OPC_BST;
  wire logic       rw  = !cs_n_i && opc[1:0] == 2'h1;
  wire logic       rd  = rw && opc[2];
  wire logic [2:0] bnk = ca_r_i[9:7] & {cfg_i.eight_bank, 2'h3};
  wire logic [4:0] nxt_since_rw = rw ? 5'h01 :
                   since_rw_ff + {4'h0, since_rw_ff != 5'h1f};
  wire logic [4:0] nxt_since_rd = rd ? 5'h01 :
                   since_rd_ff + {4'h0, since_rd_ff != 5'h1f};
  wire logic       slow_pb = cfg_i.rp_pb_ck > 6'h06;
  wire logic       slow_ab = slow_pb && cfg_i.rp_ab_ck > 6'h06;
  // Counters saturate so an old burst never looks recent again.
  always_ff @(posedge link_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      since_rw_ff <= 5'h1f;
      since_rd_ff <= 5'h1f;
    end
    else
    begin
      since_rw_ff <= nxt_since_rw;
      since_rd_ff <= nxt_since_rd;
    end
  end
  chk_pre_one_bank: assert property (
    pre && !ca_r_i[4] && slow_pb |-> ##4 !bank_open_o[$past(bnk, 4)])
    else $error("single bank stayed open after precharge");
  chk_pre_all_banks: assert property (
    pre && ca_r_i[4] && slow_ab |-> ##4 bank_open_o == 8'h00)
    else $error("bank stayed open after all-bank precharge");
  chk_all_busy: assert property (
    pre && ca_r_i[4] && cfg_i.eight_bank && slow_ab
    |-> ##4 bank_busy_o == 8'hff)
    else $error("all-bank precharge did not mark banks busy");
  chk_bst_late_refused: assert property (
    bst && since_rw_ff >= 5'h08 |-> ##[1:2] cmd_err_o)
    else $error("terminate outside a burst accepted");
  chk_err_has_cmd: assert property (
    cmd_err_o |-> $past(cs_n_i) == 1'b0 || $past(cs_n_i, 2) == 1'b0)
    else $error("refusal without a command");
  chk_read_start: assert property (
    $rose(rd_valid_o) |-> since_rd_ff >= {1'b0, cfg_i.rl}
    && since_rd_ff <= {1'b0, cfg_i.rl} + 5'h02)
    else $error("read data not at read latency");
  chk_ap_engaged: assert property (
    rw && ca_f_i[0] && bank_open_o[bnk] && !bank_busy_o[bnk] && slow_pb
    |-> ##4 bank_busy_o[$past(bnk, 4)])
    else $error("auto precharge not engaged");
  chk_no_ap_open: assert property (
    rw && !ca_f_i[0] && bank_open_o[bnk] && !bank_busy_o[bnk]
    |-> ##2 bank_open_o[$past(bnk, 2)])
    else $error("bank closed without auto precharge");
endmodule
bind lptp_device lptp_device_props u_props
(
  .rst_i       (rst_i),
  .cfg_i       (cfg_i),
  .bank_open_o (bank_open_o),
  .bank_busy_o (bank_busy_o),
  .link_clk_i  (link_clk_i),
  .cs_n_i      (cs_n_i),
  .ca_r_i      (ca_r_i),
  .ca_f_i      (ca_f_i),
  .rd_valid_o  (rd_valid_o),
  .cmd_err_o   (cmd_err_o)
);
`default_nettype wire

// File: verification/lptp_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module lptp_ctrl_model
  import lptp_pkg::*;
(
  input  wire logic       link_clk_i,
  output logic            cs_n_o,
  output logic [9:0]      ca_r_o,
  output logic [9:0]      ca_f_o,
  output lptp_pair_s      wr_pair_o
);
  initial
  begin
    cs_n_o    = 1'b1;
    ca_r_o    = 10'h000;
    ca_f_o    = 10'h000;
    wr_pair_o = '0;
  end
  // Deselected or idle lines flip every cycle so stale values never match.
  task automatic step(input logic sel, input logic [9:0] r,
                      input logic [9:0] f, input logic dv,
                      input lptp_pair_s p);
    @(posedge link_clk_i);
    cs_n_o    <= !sel;
    ca_r_o    <= sel ? r : ~ca_r_o;
    ca_f_o    <= sel ? f : ~ca_f_o;
    wr_pair_o <= dv ? p : ~wr_pair_o;
  endtask
endmodule
`default_nettype wire

// File: verification/test_lpddr2_terminate_mask_precharge.sv
`timescale 1ns/1ps
`default_nettype none
`include "lptp_params.svh"
module test_lpddr2_terminate_mask_precharge
  import lptp_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst;
  lptp_cfg_s   cfg;
  wire logic [7:0]  bank_open;
  wire logic [7:0]  bank_busy;
  wire logic        cs_n;
  wire logic [9:0]  ca_r;
  wire logic [9:0]  ca_f;
  wire lptp_pair_s  wr_pair;
  wire logic [63:0] rd_dq;
  wire logic        rd_valid;
  wire logic        cmd_err;
  logic [63:0] rdq[$];
  logic [31:0] shadow [0:15];
  int          err_seen = 0;
  int          errors = 0;
  int          total_checks = 0;
  always #10 core_clk = ~core_clk;
  always #16 link_clk = ~link_clk;
  lptp_device u_dut
  (
    .core_clk_i  (core_clk),
    .rst_i       (rst),
    .cfg_i       (cfg),
    .bank_open_o (bank_open),
    .bank_busy_o (bank_busy),
    .link_clk_i  (link_clk),
    .cs_n_i      (cs_n),
    .ca_r_i      (ca_r),
    .ca_f_i      (ca_f),
    .wr_pair_i   (wr_pair),
    .rd_dq_o     (rd_dq),
    .rd_valid_o  (rd_valid),
    .cmd_err_o   (cmd_err)
  );
  lptp_ctrl_model u_ctrl
  (
    .link_clk_i (link_clk),
    .cs_n_o     (cs_n),
    .ca_r_o     (ca_r),
    .ca_f_o     (ca_f),
    .wr_pair_o  (wr_pair)
  );
  // Link-domain outputs are taken mid-cycle, away from both edges.
  always @(negedge link_clk)
  begin
    if (rd_valid === 1'b1)
      rdq.push_back(rd_dq);
    if (cmd_err === 1'b1)
      err_seen++;
  end
  task automatic end_sim();
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  function automatic logic [9:0] ca(input logic [2:0] b, input logic ab,
                                    input logic [3:0] op);
    return {b, 2'h0, ab, op};
  endfunction
  task automatic idle(input int n);
    repeat (n) u_ctrl.step(1'b0, 10'h000, 10'h000, 1'b0, '0);
  endtask
  task automatic cmd(input logic [9:0] r);
    u_ctrl.step(1'b1, r, 10'h000, 1'b0, '0);
  endtask
  // Byte 0 of each beat carries its own mask bit; k is the terminate edge.
  task automatic wr(input logic [2:0] b, input logic ap, input int k,
                    input logic [31:0] base, input logic [15:0] msk);
    lptp_pair_s  p;
    logic [3:0]  i;
    logic [31:0] d;
    int          n;
    n = (k == 0) ? 16 : 2 * k;
    for (int e = 0; e < 10; e++)
    begin
      for (int j = 0; j < 2; j++)
      begin
        i = 4'(2 * e + j - 2);
        p.dq[j] = base + 32'(i);
        p.dm[j] = {3'h0, msk[i]};
      end
      u_ctrl.step(e == 0 || e == k,
                  e == 0 ? ca(b, 1'b0, `LPTP_OPC_WRITE)
                         : ca(3'h0, 1'b0, `LPTP_OPC_BST),
                  {9'h000, ap}, e > 0 && e < 9, p);
    end
    for (int x = 0; x < n; x++)
    begin
      d = base + 32'(x);
      shadow[x] = {d[31:8], msk[x] ? shadow[x][7:0] : d[7:0]};
    end
  endtask
  task automatic rd(input logic [2:0] b, input logic ap, input int k1,
                    input int k2, input int n);
    rdq.delete();
    for (int e = 0; e < 16; e++)
      u_ctrl.step(e == 0 || e == k1 || e == k2,
                  e == 0 ? ca(b, 1'b0, `LPTP_OPC_READ)
                         : ca(3'h0, 1'b0, `LPTP_OPC_BST),
                  {9'h000, ap}, 1'b0, '0);
    check("read pairs", 64'(n / 2), 64'(rdq.size()));
    for (int x = 0; x < rdq.size() && x < 8; x++)
      check("read beats", {shadow[2*x+1], shadow[2*x]}, rdq[x]);
  endtask
  task automatic s_mask();
    cmd(ca(3'h3, 1'b0, `LPTP_OPC_ACT));
    idle(3);
    wr(3'h3, 1'b0, 0, 32'ha000_0000, 16'h0000);
    idle(4);
    wr(3'h3, 1'b0, 0, 32'hb000_0000, 16'h5a5a);
    idle(4);
    rd(3'h3, 1'b0, 0, 0, 16);
    check("bank open", 64'h1, 64'(bank_open[3]));
  endtask
  task automatic s_term();
    int e0;
    e0 = err_seen;
    rd(3'h3, 1'b0, 2, 3, 4);
    rd(3'h3, 1'b0, 3, 0, 16);
    rd(3'h3, 1'b0, 8, 0, 16);
    check("refusals", 64'h3, 64'(err_seen - e0));
    wr(3'h3, 1'b0, 2, 32'hc000_0000, 16'h0000);
    idle(4);
    rd(3'h3, 1'b0, 0, 0, 16);
  endtask
  task automatic s_pre();
    int e0;
    e0 = err_seen;
    cmd(ca(3'h6, 1'b0, `LPTP_OPC_ACT));
    idle(4);
    cmd(ca(3'h3, 1'b0, `LPTP_OPC_PRE));
    idle(4);
    check("bank open", 64'h40, 64'(bank_open));
    cmd(ca(3'h3, 1'b0, `LPTP_OPC_ACT));
    idle(8);
    cmd(ca(3'h3, 1'b0, `LPTP_OPC_ACT));
    idle(4);
    check("bank open", 64'h48, 64'(bank_open));
    cmd(ca(3'h0, 1'b1, `LPTP_OPC_PRE));
    idle(6);
    check("bank open", 64'h0, 64'(bank_open));
    check("bank busy", 64'hff, 64'(bank_busy));
    idle(2);
    cmd(ca(3'h6, 1'b0, `LPTP_OPC_ACT));
    idle(4);
    cmd(ca(3'h6, 1'b0, `LPTP_OPC_ACT));
    idle(4);
    check("bank open", 64'h40, 64'(bank_open));
    check("refusals", 64'h2, 64'(err_seen - e0));
  endtask
  task automatic s_ap();
    wr(3'h6, 1'b0, 0, 32'hd000_0000, 16'h0000);
    idle(4);
    rd(3'h6, 1'b1, 0, 0, 16);
    check("bank open", 64'h0, 64'(bank_open[6]));
    idle(10);
    cmd(ca(3'h6, 1'b0, `LPTP_OPC_ACT));
    idle(4);
    wr(3'h6, 1'b1, 0, 32'he000_0000, 16'h0000);
    idle(1);
    check("bank open", 64'h1, 64'(bank_open[6]));
    idle(5);
    check("bank open", 64'h0, 64'(bank_open[6]));
  endtask
  initial
  begin
    #200_000;
    errors++;
    end_sim();
  end
  initial
  begin
    rst = 1'b1;
    cfg = '{5'h10, 4'h3, 4'h1, 4'h2, 4'h2, 6'h08, 6'h0c, 1'b1};
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    idle(8);
    s_mask();
    s_term();
    s_pre();
    s_ap();
    end_sim();
  end
endmodule
`default_nettype wire
